/* core/pmb_power_boot.sv */
// How it works
// - Boot select pin low flash, high USB
// - ROM boot, then flash boot, then application
// - ROM checks flash boot; flash boot enables debug port
// - Failed application check enters safe state
// - Hold for bad supply; brownout resets
// - CPU deep sleep halts and requests system sleep
// - Suspend and deep sleep only when both CPUs sleep
// - Normal mode enables CPU clock and PLLs
// - Suspend keeps only PHY U3 clock and low-speed oscillator running
// - Suspend holds pins and retains memories
// - Non-reset suspend wake keeps program counter
// - Suspend wake sources listed, plus reset
// - Deep sleep stops crystal, PLL, PHY; retains
// - Deep sleep wakes on GPIO, I2C, parallel, reset
// - Deep sleep wake restarts core from RAM
// - Power-down loses all; exits by supply+reset
// - Low-speed oscillator runs in every mode
//
// Power mode and staged boot sequencer for the device core.
// Assumes firmware status strobes on clock_i; pins are asynchronous.
`timescale 1ns/1ps
module pmb_power_boot
   import pmb_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic external_reset_n_i,
   input wire logic boot_source_select_i,
   input wire logic supply_good_i,
   input wire logic brownout_detector_i,
   input wire logic rom_done_i,
   input wire logic flashboot_valid_i,
   input wire logic flashboot_done_i,
   input wire logic app_valid_i,
   input wire logic [NUM_CPU-1:0] cpu_deep_sleep_i,
   input wire logic [1:0] mode_req_i,
   input wire logic [WK_W-1:0] wake_pins_i,
   output logic [NUM_CPU-1:0] cpu_halt_o,
   output logic sys_sleep_req_o,
   output logic chip_reset_o,
   output pmb_power_t power_o,
   output pmb_boot_t boot_o,
   output logic [2:0] mode_o
);

   // Two-stage synchronisers for asynchronous pins
   logic [WK_W-1:0] wake_meta_reg;
   logic [WK_W-1:0] wake_sync_reg;
   logic [WK_W-1:0] wake_prev_reg;
   logic external_reset_n_meta_reg;
   logic external_reset_n_sync_reg;
   logic bsel_meta_reg;
   logic bsel_sync_reg;
   logic pwr_meta_reg;
   logic pwr_sync_reg;
   logic bod_meta_reg;
   logic bod_sync_reg;

   // Sequencer state and supporting registers
   pmb_state_t state_reg;
   pmb_state_t state_next;
   logic [CNT_W-1:0] settle_reg;
   logic boot_usb_reg;
   logic pc_reset_reg;
   logic [NUM_CPU-1:0] halt_reg;
   logic sleep_req_reg;
   logic reset_out_reg;
   pmb_power_t power_reg;
   pmb_power_t power_next;
   pmb_boot_t boot_reg;
   logic [2:0] mode_reg;

   // Wake detection per mode
   logic [WK_W-1:0] wake_edge;
   logic wake_suspend;
   logic wake_deep;
   logic external_reset_n_asserted;
   pmb_req_t req;

   // Mask a wake vector and report whether any source fired
   function automatic logic any_wake(input logic [WK_W-1:0] v, input logic [WK_W-1:0] m);
      any_wake = |(v & m);
   endfunction : any_wake

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_meta_reg <= '0;
         wake_sync_reg <= '0;
         external_reset_n_meta_reg <= 1'b1;
         external_reset_n_sync_reg <= 1'b1;
         bsel_meta_reg <= BOOT_FROM_FLASH;
         bsel_sync_reg <= BOOT_FROM_FLASH;
         pwr_meta_reg <= 1'b0;
         pwr_sync_reg <= 1'b0;
         bod_meta_reg <= 1'b0;
         bod_sync_reg <= 1'b0;
      end else begin
         wake_meta_reg <= wake_pins_i;
         wake_sync_reg <= wake_meta_reg;
         external_reset_n_meta_reg <= external_reset_n_i;
         external_reset_n_sync_reg <= external_reset_n_meta_reg;
         bsel_meta_reg <= boot_source_select_i;
         bsel_sync_reg <= bsel_meta_reg;
         pwr_meta_reg <= supply_good_i;
         pwr_sync_reg <= pwr_meta_reg;
         bod_meta_reg <= brownout_detector_i;
         bod_sync_reg <= bod_meta_reg;
      end
   end

   // Previous synced wake levels for transition detection
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_prev_reg <= '0;
      end else begin
         wake_prev_reg <= wake_sync_reg;
      end
   end

   // D+/D- wake on either transition, others on asserted level
   always_comb begin
      wake_edge = wake_sync_reg;
      wake_edge[WK_DP] = wake_sync_reg[WK_DP] ^ wake_prev_reg[WK_DP];
      wake_edge[WK_DM] = wake_sync_reg[WK_DM] ^ wake_prev_reg[WK_DM];
   end

   assign external_reset_n_asserted = !external_reset_n_sync_reg;
   assign wake_suspend = any_wake(wake_edge, WK_SUSPEND_MASK);
   assign wake_deep = any_wake(wake_edge, WK_DEEP_MASK);
   assign req = pmb_req_t'(mode_req_i);

   // Supply settle counter after the supply reports good
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         settle_reg <= '0;
      end else if (state_reg != PMB_ST_POR || !pwr_sync_reg) begin
         settle_reg <= '0;
      end else if (settle_reg != CNT_W'(POR_SETTLE_CYC)) begin
         settle_reg <= settle_reg + 1'b1;
      end
   end

   // Next state of the sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         // Supply must be good and settled before boot
         PMB_ST_POR: begin
            if (pwr_sync_reg && settle_reg == CNT_W'(POR_SETTLE_CYC)) begin
               state_next = PMB_ST_ROM;
            end
         end
         // ROM runs first; it validates the flash boot code
         PMB_ST_ROM: begin
            if (rom_done_i) begin
               state_next = flashboot_valid_i ? PMB_ST_FLASHBOOT : PMB_ST_SAFE;
            end
         end
         // Flash boot then checks the application
         PMB_ST_FLASHBOOT: begin
            if (flashboot_done_i) begin
               state_next = app_valid_i ? PMB_ST_APP : PMB_ST_SAFE;
            end
         end
         // Application: suspend and deep sleep entry need both CPUs asleep; power-down needs none
         PMB_ST_APP: begin
            if (req == PMB_REQ_POWERDOWN) begin
               state_next = PMB_ST_OFF;
            end else if (&cpu_deep_sleep_i && req == PMB_REQ_SUSPEND) begin
               state_next = PMB_ST_SUSPEND;
            end else if (&cpu_deep_sleep_i && req == PMB_REQ_DEEP) begin
               state_next = PMB_ST_DEEP;
            end
         end
         // Safe state is held until a reset
         PMB_ST_SAFE: begin
            state_next = PMB_ST_SAFE;
         end
         // Suspend resumes in place on any non-reset source except the parallel pin
         PMB_ST_SUSPEND: begin
            if (wake_suspend) begin
               state_next = PMB_ST_APP;
            end
         end
         // Deep sleep wake restarts the core from RAM
         PMB_ST_DEEP: begin
            if (wake_deep) begin
               state_next = PMB_ST_APP;
            end
         end
         // Power-down: only supply and reset bring it back
         PMB_ST_OFF: begin
            state_next = PMB_ST_OFF;
         end
      endcase
   end

   // State register; reset sources override everything
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= PMB_ST_POR;
      end else if (external_reset_n_asserted || bod_sync_reg) begin
         state_reg <= PMB_ST_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   // Boot source captured once supply settles, not at reset
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_usb_reg <= BOOT_FROM_FLASH;
      end else if (state_reg == PMB_ST_POR && state_next == PMB_ST_ROM) begin
         boot_usb_reg <= bsel_sync_reg;
      end
   end

   // Core restart pulse: deep sleep wake and every fresh boot
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pc_reset_reg <= 1'b0;
      end else begin
         pc_reset_reg <= (state_reg == PMB_ST_DEEP && state_next == PMB_ST_APP)
            || (state_reg == PMB_ST_POR && state_next == PMB_ST_ROM);
      end
   end

   // Per-CPU halt and system sleep request
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         halt_reg <= '0;
         sleep_req_reg <= 1'b0;
      end else begin
         halt_reg <= cpu_deep_sleep_i;
         sleep_req_reg <= |cpu_deep_sleep_i;
      end
   end

   // Chip reset output while held in supply or reset hold
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reset_out_reg <= 1'b1;
      end else begin
         reset_out_reg <= (state_next == PMB_ST_POR) || external_reset_n_asserted || bod_sync_reg;
      end
   end

   // Clock and power enables per mode
   always_comb begin
      power_next = '0;
      power_next.lowspeed_osc_en = 1'b1;
      unique case (state_next)
         PMB_ST_SUSPEND: begin
            power_next.phy_u3_clk_en = 1'b1;
            power_next.io_hold = 1'b1;
            power_next.ram_retain = 1'b1;
         end
         PMB_ST_DEEP: begin
            power_next.io_hold = 1'b1;
            power_next.ram_retain = 1'b1;
         end
         PMB_ST_OFF: begin
            power_next.ram_retain = 1'b0;
         end
         PMB_ST_POR: begin
            power_next.cpu_clk_en = 1'b0;
         end
         default: begin
            power_next.cpu_clk_en = 1'b1;
            power_next.pll_en = 1'b1;
            power_next.xtal_en = 1'b1;
            power_next.usb_phy_en = 1'b1;
         end
      endcase
   end

   // Power enable register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         power_reg <= '{lowspeed_osc_en: 1'b1, default: 1'b0};
      end else if (external_reset_n_asserted || bod_sync_reg) begin
         power_reg <= '{lowspeed_osc_en: 1'b1, default: 1'b0};
      end else begin
         power_reg <= power_next;
      end
   end

   // Boot stage controls and mode code
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_reg <= '0;
         mode_reg <= '0;
      end else begin
         boot_reg.run_rom <= state_reg == PMB_ST_ROM;
         boot_reg.run_flashboot <= state_reg == PMB_ST_FLASHBOOT;
         boot_reg.run_app <= state_reg == PMB_ST_APP;
         boot_reg.dbg_port_en <= state_reg == PMB_ST_FLASHBOOT || state_reg == PMB_ST_APP;
         boot_reg.safe_state <= state_reg == PMB_ST_SAFE;
         boot_reg.boot_usb <= boot_usb_reg;
         boot_reg.pc_reset <= pc_reset_reg;
         mode_reg <= 3'(state_reg);
      end
   end

   assign cpu_halt_o = halt_reg;
   assign sys_sleep_req_o = sleep_req_reg;
   assign chip_reset_o = reset_out_reg;
   assign power_o = power_reg;
   assign boot_o = boot_reg;
   assign mode_o = mode_reg;

   // Checks beside the logic they guard
   // Both halts stood on the cycle the mode code still showed APP
   sequence s_all_asleep;
      $past(cpu_halt_o) == {NUM_CPU{1'b1}};
   endsequence

   // Judged on the outputs, so a broken entry condition shows up here
   chk_sleep_needs_both: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (mode_o == 3'(PMB_ST_SUSPEND) || mode_o == 3'(PMB_ST_DEEP))
      && $past(mode_o) == 3'(PMB_ST_APP) |-> s_all_asleep)
      else $error("low power entered without both CPUs asleep");

   chk_suspend_clocks: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (state_reg == PMB_ST_SUSPEND && $past(state_reg) == PMB_ST_SUSPEND)
      |-> power_o.phy_u3_clk_en && !power_o.cpu_clk_en && !power_o.pll_en)
      else $error("suspend clock gating wrong");

   chk_lowspeed_runs: assert property (@(posedge clock_i) disable iff (!resetn_i)
      power_o.lowspeed_osc_en)
      else $error("low speed oscillator stopped");

   chk_bod_resets: assert property (@(posedge clock_i) disable iff (!resetn_i)
      bod_sync_reg |=> state_reg == PMB_ST_POR ##0 chip_reset_o)
      else $error("brownout did not reset");

   chk_boot_order: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(state_reg == PMB_ST_APP) && $past(state_reg) != PMB_ST_SUSPEND
      && $past(state_reg) != PMB_ST_DEEP |-> $past(state_reg) == PMB_ST_FLASHBOOT)
      else $error("application started out of order");

   chk_bad_app_safe: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (state_reg == PMB_ST_FLASHBOOT && flashboot_done_i && !app_valid_i
      && !external_reset_n_asserted && !bod_sync_reg) |=> state_reg == PMB_ST_SAFE ##1 boot_o.safe_state)
      else $error("invalid application not trapped");

   chk_deep_wake_restart: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (state_reg == PMB_ST_DEEP && state_next == PMB_ST_APP && !external_reset_n_asserted
      && !bod_sync_reg) |=> ##1 boot_o.pc_reset)
      else $error("deep sleep wake did not restart core");

   chk_deep_power_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
      (state_reg == PMB_ST_DEEP && $past(state_reg) == PMB_ST_DEEP)
      |-> !power_o.xtal_en && !power_o.usb_phy_en && power_o.ram_retain)
      else $error("deep sleep gating wrong");

endmodule : pmb_power_boot

/* core/pmb_pkg.sv */
// Shared types and constants for the power mode and boot controller.
// Assumes a single 100 MHz system clock and an active-low async reset.
package pmb_pkg;

   // Clock rate and the wake-pin synchroniser depth
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SYNC_STAGES = 2;

   // Power-on supply settle time in ns, and its count in cycles
   localparam int unsigned POR_SETTLE_NS = 1000;
   localparam int unsigned POR_SETTLE_CYC = (POR_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CNT_W = 8;

   // Boot source encodings of the select pin
   localparam logic BOOT_FROM_FLASH = 1'b0;
   localparam logic BOOT_FROM_USB = 1'b1;

   // Number of CPUs that must agree on deep sleep
   localparam int unsigned NUM_CPU = 2;

   // Wake source bit positions inside the wake vector
   localparam int unsigned WK_SS_RX = 0;
   localparam int unsigned WK_DP = 1;
   localparam int unsigned WK_DM = 2;
   localparam int unsigned WK_VBUS = 3;
   localparam int unsigned WK_GPIO = 4;
   localparam int unsigned WK_I2C = 5;
   localparam int unsigned WK_CTL = 6;
   localparam int unsigned WK_PAR = 7;
   localparam int unsigned WK_W = 8;

   // Sources that may end suspend and deep sleep respectively
   localparam logic [WK_W-1:0] WK_SUSPEND_MASK = 8'h7f;
   localparam logic [WK_W-1:0] WK_DEEP_MASK = 8'hb0;

   // Requested low-power mode from firmware
   typedef enum logic [1:0] {
      PMB_REQ_NONE,
      PMB_REQ_SUSPEND,
      PMB_REQ_DEEP,
      PMB_REQ_POWERDOWN
   } pmb_req_t;

   // Sequencer states
   typedef enum {
      PMB_ST_POR,
      PMB_ST_ROM,
      PMB_ST_FLASHBOOT,
      PMB_ST_APP,
      PMB_ST_SAFE,
      PMB_ST_SUSPEND,
      PMB_ST_DEEP,
      PMB_ST_OFF
   } pmb_state_t;

   // Clock and power gating outputs, grouped
   typedef struct packed {
      logic cpu_clk_en;
      logic pll_en;
      logic xtal_en;
      logic usb_phy_en;
      logic phy_u3_clk_en;
      logic lowspeed_osc_en;
      logic io_hold;
      logic ram_retain;
   } pmb_power_t;

   // Boot stage controls toward the CPU complex
   typedef struct packed {
      logic run_rom;
      logic run_flashboot;
      logic run_app;
      logic dbg_port_en;
      logic boot_usb;
      logic safe_state;
      logic pc_reset;
   } pmb_boot_t;

endpackage : pmb_pkg

/* bench/pmb_fw_model.sv */
// Firmware and CPU complex model facing the power and boot sequencer.
// Assumes boot stage levels from the sequencer and commands from the bench.
`timescale 1ns/1ps
module pmb_fw_model
   import pmb_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire pmb_boot_t boot_i,
   input wire logic [2:0] lat_i,
   input wire logic bad_flash_i,
   input wire logic bad_app_i,
   input wire logic [NUM_CPU-1:0] sleep_cpus_i,
   input wire logic [1:0] req_i,
   output logic rom_done_o,
   output logic flashboot_valid_o,
   output logic flashboot_done_o,
   output logic app_valid_o,
   output logic [NUM_CPU-1:0] cpu_deep_sleep_o,
   output logic [1:0] mode_req_o
);
   logic [2:0] wait_reg; // Cycles spent in the running stage
   logic hit; // Stage answer is due
   logic stage; // ROM or flash boot stage running

   assign hit = (wait_reg == lat_i);
   assign stage = boot_i.run_rom | boot_i.run_flashboot;

   // Stage answers, slow or prompt; results toggle outside their strobe
   // so a sequencer that samples them at the wrong time sees junk
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_reg <= 3'h0;
         rom_done_o <= 1'b0;
         flashboot_done_o <= 1'b0;
         flashboot_valid_o <= 1'b0;
         app_valid_o <= 1'b0;
      end else begin
         wait_reg <= (stage && !hit) ? wait_reg + 3'h1 : 3'h0;
         rom_done_o <= boot_i.run_rom & hit;
         flashboot_done_o <= boot_i.run_flashboot & hit;
         flashboot_valid_o <= (boot_i.run_rom & hit) ? !bad_flash_i : !flashboot_valid_o;
         app_valid_o <= (boot_i.run_flashboot & hit) ? !bad_app_i : !app_valid_o;
      end
   end

   // CPUs report deep sleep first; the mode request follows a cycle later
   // with no transaction left open; power-down needs no sleeping CPU
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cpu_deep_sleep_o <= '0;
         mode_req_o <= 2'h0;
      end else begin
         cpu_deep_sleep_o <= sleep_cpus_i;
         if (req_i == PMB_REQ_POWERDOWN || cpu_deep_sleep_o != '0) begin
            mode_req_o <= req_i;
         end else begin
            mode_req_o <= 2'h0;
         end
      end
   end
endmodule : pmb_fw_model

/* bench/test_power_mode_boot_control.sv */
// Self-checking bench for the power mode and staged boot sequencer.
// Assumes the firmware model pmb_fw_model and a 100 MHz clock.
`timescale 1ns/1ps
module test_power_mode_boot_control
   import pmb_pkg::*;
();
   logic clock_i, resetn_i, ext_rstn, boot_sel, supply_good, brownout;
   logic rom_done, fb_valid, fb_done, app_valid, sys_req, chip_rst;
   logic bad_flash, bad_app, pc_seen;
   logic [NUM_CPU-1:0] cpu_sleep, cpu_halt, sleep_cpus;
   logic [1:0] mode_req, req;
   logic [WK_W-1:0] wake;
   logic [2:0] mode, lat;
   logic [11:0] hist; // Last three modes, one nibble each
   pmb_power_t power;
   pmb_boot_t boot;
   int errors, n_checks, seed, i;
   int deep_src[3] = '{WK_GPIO, WK_I2C, WK_PAR};

   pmb_power_boot dut (.clock_i(clock_i), .resetn_i(resetn_i), .external_reset_n_i(ext_rstn),
      .boot_source_select_i(boot_sel), .supply_good_i(supply_good),
      .brownout_detector_i(brownout), .rom_done_i(rom_done), .flashboot_valid_i(fb_valid),
      .flashboot_done_i(fb_done), .app_valid_i(app_valid), .cpu_deep_sleep_i(cpu_sleep),
      .mode_req_i(mode_req), .wake_pins_i(wake), .cpu_halt_o(cpu_halt),
      .sys_sleep_req_o(sys_req), .chip_reset_o(chip_rst), .power_o(power), .boot_o(boot),
      .mode_o(mode));

   pmb_fw_model fw (.clock_i(clock_i), .resetn_i(resetn_i), .boot_i(boot), .lat_i(lat),
      .bad_flash_i(bad_flash), .bad_app_i(bad_app), .sleep_cpus_i(sleep_cpus), .req_i(req),
      .rom_done_o(rom_done), .flashboot_valid_o(fb_valid), .flashboot_done_o(fb_done),
      .app_valid_o(app_valid), .cpu_deep_sleep_o(cpu_sleep), .mode_req_o(mode_req));

   // Free-running system clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Mode history and restart pulse watcher
   always @(posedge clock_i) begin
      if ({1'b0, mode} !== hist[3:0]) hist <= {hist[7:0], 1'b0, mode};
      if (boot.pc_reset === 1'b1) pc_seen <= 1'b1;
   end

   // Expected power bits per mode as {mask, value}
   function automatic logic [15:0] exp_pwr(input logic [2:0] m);
      case (m)
         3'h3: exp_pwr = {8'hc4, 8'hc4};
         3'h5: exp_pwr = {8'hef, 8'h0f};
         3'h6: exp_pwr = {8'h75, 8'h05};
         default: exp_pwr = {8'hff, 8'h04};
      endcase
   endfunction : exp_pwr

   // Inputs move 1 ns after the edge so sampling never races
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : step

   task automatic chk_bits(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_bits

   task automatic chk_mode(input string what, input logic [2:0] exp);
      n_checks++;
      if (mode !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, mode);
      end
   endtask : chk_mode

   // Bounded wait for a mode; a timeout shows up as a mismatch
   task automatic reach(input string what, input logic [2:0] m, input int limit);
      int k;
      for (k = 0; k < limit && mode !== m; k++) step(1);
      chk_mode(what, m);
   endtask : reach

   task automatic pwr_check();
      logic [15:0] e;
      e = exp_pwr(mode);
      chk_bits("power", {8'h0, e[7:0]}, {8'h0, power & e[15:8]});
   endtask : pwr_check

   task automatic end_test(input string name);
      $display("test %s done, errors so far %0d", name, errors);
   endtask : end_test

   // Pin reset, then a full boot with random stage latency and source
   task automatic boot_up(input logic bf, input logic ba);
      logic bad;
      bad = bf | ba;
      boot_sel = 1'($random(seed));
      lat = 3'($random(seed));
      bad_flash = bf;
      bad_app = ba;
      req = 2'h0;
      sleep_cpus = '0;
      wake = '0;
      ext_rstn = 1'b0;
      step(4);
      chk_bits("chip_reset", 16'h1, {15'h0, chip_rst});
      hist = 12'h0;
      ext_rstn = 1'b1;
      reach("boot end", bad ? 3'h4 : 3'h3, 400);
      step(2);
      chk_bits("order", bf ? 16'h014 : (ba ? 16'h124 : 16'h123), {4'h0, hist});
      chk_bits("boot", {9'h0, bad ? 7'h02 : {4'h3, boot_sel, 2'h0}},
         {9'h0, boot & (bad ? 7'h1a : 7'h1e)});
   endtask : boot_up

   // Both CPUs asleep (none for power-down), then a mode request; power checked in the new mode
   task automatic enter(input logic [1:0] r, input logic [2:0] m);
      sleep_cpus = (r == 2'h3) ? 2'h0 : 2'h3;
      req = r;
      reach("enter", m, 30);
      pwr_check();
      sleep_cpus = '0;
      req = 2'h0;
      pc_seen = 1'b0;
      step(2);
   endtask : enter

   task automatic wake_by(input int b, input logic [2:0] m);
      wake = '0;
      wake[b] = 1'b1;
      reach("wake", m, 12);
      wake = '0;
      step(4);
   endtask : wake_by

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog well beyond the expected run of a few thousand cycles
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end

   initial begin
      seed = 32'h8d88;
      errors = 0;
      n_checks = 0;
      {resetn_i, ext_rstn, boot_sel, supply_good, brownout} = 5'b01000;
      {bad_flash, bad_app, pc_seen, req, sleep_cpus, lat, hist} = '0;
      wake = '0;
      step(12);
      chk_mode("reset mode", 3'h0);
      pwr_check();
      chk_bits("chip_reset", 16'h1, {15'h0, chip_rst});
      resetn_i = 1'b1;
      step(200);
      chk_mode("supply hold", 3'h0);
      supply_good = 1'b1;
      for (i = 0; i < 3; i++) begin
         boot_up(1'b0, 1'b0);
         pwr_check();
      end
      end_test("boot");
      boot_up(1'b1, 1'b0);
      wake = '1;
      step(10);
      chk_mode("safe holds", 3'h4);
      boot_up(1'b0, 1'b1);
      end_test("safe");
      boot_up(1'b0, 1'b0);
      brownout = 1'b1;
      step(5);
      chk_mode("brownout", 3'h0);
      chk_bits("chip_reset", 16'h1, {15'h0, chip_rst});
      brownout = 1'b0;
      reach("reboot", 3'h3, 400);
      end_test("brownout");
      sleep_cpus = 2'h1;
      req = PMB_REQ_SUSPEND;
      step(3);
      chk_bits("halt", 16'h5, {13'h0, sys_req, cpu_halt});
      step(10);
      chk_mode("one cpu", 3'h3);
      for (i = 0; i < 7; i++) begin
         enter(PMB_REQ_SUSPEND, 3'h5);
         wake_by(i, 3'h3);
         chk_bits("pc kept", 16'h0, {15'h0, pc_seen});
      end
      enter(PMB_REQ_SUSPEND, 3'h5);
      ext_rstn = 1'b0;
      step(4);
      chk_mode("reset wake", 3'h0);
      ext_rstn = 1'b1;
      reach("reboot", 3'h3, 400);
      end_test("suspend");
      foreach (deep_src[j]) begin
         enter(PMB_REQ_DEEP, 3'h6);
         wake[WK_VBUS] = 1'b1;
         step(10);
         chk_mode("deep vbus", 3'h6);
         wake_by(deep_src[j], 3'h3);
         chk_bits("pc restart", 16'h1, {15'h0, pc_seen});
      end
      end_test("deep");
      enter(PMB_REQ_POWERDOWN, 3'h7);
      wake = '1;
      step(20);
      chk_mode("off holds", 3'h7);
      boot_up(1'b0, 1'b0);
      end_test("off");
      tally_and_finish();
   end
endmodule : test_power_mode_boot_control
